// *** pkg/ocs_pkg.sv ***
/*
 Package for the command interpreter of the common-level, nonvolatile-memory and
 test-mode command group. Assumes the serial front end delivers whole bytes with a
 command/parameter flag on the ref_clk domain.
*/
package ocs_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_MEASURE_SETUP   = 8'h80;
    localparam logic [7:0] CMD_LEVEL_READBACK  = 8'h81;
    localparam logic [7:0] CMD_DC_SETTING      = 8'h82;
    localparam logic [7:0] CMD_ENTER_PROGRAM   = 8'h90;
    localparam logic [7:0] CMD_PROGRAM_ACT     = 8'h91;
    localparam logic [7:0] CMD_NVM_READ        = 8'h92;
    localparam logic [7:0] CMD_FRAME_MEM_READ  = 8'h93;
    localparam logic [7:0] CMD_PROG_CONFIG     = 8'hA2;
    localparam logic [7:0] CMD_PROG_RESULT     = 8'hA3;
    localparam logic [7:0] CMD_HIGH_RAIL_COMP  = 8'hA8;
    localparam logic [7:0] CMD_GATE_STRENGTH   = 8'hC9;
    localparam logic [7:0] CMD_PUMP_SEL        = 8'hDB;
    localparam logic [7:0] CMD_PUMP_EN         = 8'hDC;
    localparam logic [7:0] CMD_PUMP_HIGH       = 8'hDD;
    localparam logic [7:0] CMD_PUMP_LOW        = 8'hDE;
    localparam logic [7:0] CMD_SOURCE_RAIL     = 8'hDF;
    localparam logic [7:0] CMD_TEMP_PATH       = 8'hE0;
    localparam logic [7:0] CMD_LOW_VOLT        = 8'hE4;
    localparam logic [7:0] CMD_FORCED_TEMP     = 8'hE6;
    localparam logic [7:0] CMD_BOOST_PWM       = 8'hEF;
    localparam logic [7:0] CMD_TEST            = 8'hFF;
    localparam logic [7:0] CMD_PANEL_SETTING   = 8'h00;
    localparam logic [7:0] CMD_DATA_TRANSMIT   = 8'h10;
    localparam logic [7:0] TEST_ENTER_CODE     = 8'hA5;
    localparam logic [7:0] TEST_EXIT_CODE      = 8'hE3;
    // ==========================================================
    // Reset values
    localparam logic [7:0]  RST_MEASURE        = 8'h00;
    localparam logic [7:0]  RST_DC             = 8'h00;
    localparam logic [7:0]  RST_PROG_CFG       = 8'h00;
    localparam logic [15:0] RST_PROG_ADDR      = 16'h0000;
    localparam logic [15:0] RST_PROG_SIZE      = 16'h15DF;
    localparam logic [7:0]  RST_HIGH_RAIL      = 8'h3F;
    localparam logic [7:0]  RST_GATE_STRENGTH  = 8'hF8;
    localparam logic [7:0]  RST_PUMP_SEL       = 8'h03;
    localparam logic [7:0]  RST_PUMP_EN        = 8'h03;
    localparam logic [7:0]  RST_PUMP_HIGH      = 8'h08;
    localparam logic [7:0]  RST_PUMP_LOW       = 8'h08;
    localparam logic [7:0]  RST_SOURCE_RAIL    = 8'h3F;
    localparam logic [7:0]  RST_TEMP_PATH      = 8'h00;
    localparam logic [7:0]  RST_LOW_VOLT       = 8'h03;
    localparam logic [7:0]  RST_FORCED_TEMP    = 8'h00;
    localparam logic [63:0] RST_BOOST_PWM      = 64'h0103030A04200620;
    // ==========================================================
    // Field positions
    localparam int POS_ALL_GATE      = 3;
    localparam int POS_SOURCE_LEVEL  = 2;
    localparam int POS_ANALOG_PATH   = 1;
    localparam int POS_MEASURE_EN    = 0;
    localparam int POS_SENSE_TIME    = 4;
    localparam int POS_DC_SOURCE     = 7;
    localparam int POS_PROG_VOLT     = 4;
    localparam int POS_MASTER_DIS    = 1;
    localparam int POS_SLAVE_DIS     = 0;
    localparam int POS_VERIFY_FAIL   = 1;
    localparam int POS_SET_INVALID   = 0;
    localparam int POS_FIXED_TEMP    = 1;
    localparam int POS_CASCADE_EN    = 0;
    localparam logic [6:0] LEVEL_CODE_MAX = 7'h50;
    localparam logic signed [7:0] TEMP_MIN = 8'hE7;
    localparam logic signed [7:0] TEMP_MAX = 8'h3C;
    // ==========================================================
    // Times
    localparam int CLK_MHZ          = 250;
    localparam int SENSE_STEP_S     = 5;
    localparam int CASCADE_SYNC_US  = 1000;
    localparam int CASCADE_SYNC_CYC = CASCADE_SYNC_US * CLK_MHZ;
    localparam longint SENSE_STEP_CYC = longint'(SENSE_STEP_S) * 1000000 * CLK_MHZ;
    localparam int PROG_CYC_PER_BYTE = 16;

    typedef enum logic [2:0] {
        OCS_IDLE    = 3'b000,
        OCS_PARAM   = 3'b001,
        OCS_READ    = 3'b010,
        OCS_PROGRAM = 3'b011,
        OCS_SYNC    = 3'b100
    } ocs_state_t;
endpackage

// *** rtl/ocs_cmd.sv ***
/*
 Command interpreter for the common-level, nonvolatile-memory programming, readback,
 temperature path and test-mode commands. Assumes a serial front end that hands over
 bytes on ref_clk with a command/parameter flag and read strobes, and external memories
 that answer a read address in the same cycle.
*/
// How it works
// - Sense time field picks 5/10/15/20 s.
// - All-gate bit turns every gate on, only while enable is set.
// - Source-level bit picks 0 V or low rail.
// - Analog bit: readback value or external probe.
// - Measurement runs only while enable is set.
// - Readback returns 7-bit negative-step code, max 0x50.
// - DC top bit picks IP or written value.
// - DC low bits set level, default zero.
// - 90H enters program mode until hardware reset.
// - 91H starts programming, busy low until done.
// - 91H accepted only while not busy.
// - 92H reads dummy then nonvolatile bytes from zero.
// - 93H reads dummy then frame bytes from zero.
// - Config bit 4 picks programming voltage source.
// - Role-disable bits block four specific commands.
// - Config holds start address, size, high first.
// - Status reports verify fail and invalid setting.
// - Cascade enable drives clock out, else low.
// - Cascade enable syncs temperature about 1 ms.
// - Fixed-temp bit replaces sensor with forced byte.
// - Forced byte is two's complement, -25 to 60.
// - Low-voltage code picks 2.2 to 2.5 V.
// - FFH A5 enters test mode, E3 leaves.
module ocs_cmd #(
    parameter int ADDR_W         = 16,
    parameter int CASCADE_CYCLES = ocs_pkg::CASCADE_SYNC_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic                  byte_valid,
    input  wire logic                  byte_is_cmd,
    input  wire logic [7:0]            byte_data,
    input  wire logic                  read_req,
    output logic [7:0]                 read_data,
    output logic                       busy_n,
    input  wire logic                  role_select_pin,
    output logic                       cascade_clock_pin,
    input  wire logic [6:0]            measured_level,
    input  wire logic [7:0]            sensor_temp,
    output logic [ADDR_W-1:0]          nvm_addr,
    input  wire logic [7:0]            nvm_rdata,
    output logic [ADDR_W-1:0]          frame_addr,
    input  wire logic [7:0]            frame_rdata,
    input  wire logic                  prog_verify_fail_in,
    output logic                       program_mode,
    output logic                       prog_running,
    output logic                       prog_voltage_sel,
    output logic [15:0]                prog_start_addr,
    output logic [15:0]                prog_data_size,
    output logic                       auto_measure_en,
    output logic                       all_gate_on_sel,
    output logic                       source_level_sel,
    output logic                       analog_probe_sel,
    output logic [1:0]                 sense_time_sel,
    output logic [6:0]                 dc_level,
    output logic                       dc_level_source_sel,
    output logic [7:0]                 temperature_value,
    output logic [1:0]                 low_voltage_sel,
    output logic                       test_mode,
    output logic [7:0]                 high_rail_comp,
    output logic [7:0]                 gate_strength,
    output logic [7:0]                 pump_sel,
    output logic [7:0]                 pump_en,
    output logic [7:0]                 pump_high,
    output logic [7:0]                 pump_low,
    output logic [7:0]                 source_rail,
    output logic [63:0]                boost_pwm
);
    import ocs_pkg::*;

    if (ADDR_W < 16 || CASCADE_CYCLES < 1) begin : g_param_check
        $error("ocs_cmd: unsupported parameters");
    end

    // ==========================================================
    // Synchronised pins
    logic role_meta_reg, role_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            role_meta_reg <= 1'b0;
            role_reg      <= 1'b0;
        end else begin
            role_meta_reg <= role_select_pin;
            role_reg      <= role_meta_reg;
        end
    end

    // ==========================================================
    // Command decode
    ocs_state_t  state_reg;
    logic [7:0]  cmd_reg;
    logic [2:0]  pidx_reg;
    logic        dummy_reg;
    logic [7:0]  meas_reg, dc_reg, cfg_reg, temp_path_reg, lv_reg, ftemp_reg;
    logic [15:0] saddr_reg, dsize_reg, prog_cnt_reg;
    logic [7:0]  hr_reg, gs_reg, ps_reg, pe_reg, ph_reg, pl_reg, sr_reg;
    logic [63:0] pwm_reg;
    logic        test_reg, pgm_mode_reg, verify_fail_reg, invalid_reg;
    logic [31:0] sync_cnt_reg;
    logic [ADDR_W-1:0] rd_addr_reg;

    logic cmd_blocked;
    logic is_cmd, is_param;
    assign is_cmd   = byte_valid && byte_is_cmd;
    assign is_param = byte_valid && !byte_is_cmd;
    // Role high is master.
    assign cmd_blocked = ((role_reg && cfg_reg[POS_MASTER_DIS]) ||
                          (!role_reg && cfg_reg[POS_SLAVE_DIS])) &&
                         (byte_data == CMD_DATA_TRANSMIT || byte_data == CMD_ENTER_PROGRAM ||
                          byte_data == CMD_PROGRAM_ACT || byte_data == CMD_PANEL_SETTING);

    logic busy_now;
    assign busy_now = (state_reg == OCS_PROGRAM) || (state_reg == OCS_SYNC);
    assign busy_n   = !busy_now;

    // Programming is started from the activate command or refused as invalid.
    logic prog_start;
    logic prog_invalid;
    assign prog_start   = is_cmd && byte_data == CMD_PROGRAM_ACT && !busy_now && !cmd_blocked
                          && pgm_mode_reg && dsize_reg != 16'h0000;
    assign prog_invalid = is_cmd && byte_data == CMD_PROGRAM_ACT && !busy_now && !cmd_blocked
                          && (!pgm_mode_reg || dsize_reg == 16'h0000);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= OCS_IDLE;
            cmd_reg      <= 8'h00;
            pidx_reg     <= 3'h0;
            prog_cnt_reg <= 16'h0000;
            sync_cnt_reg <= 32'h0;
        end else begin
            case (state_reg)
                OCS_IDLE, OCS_PARAM, OCS_READ: begin
                    if (prog_start) begin
                        state_reg    <= OCS_PROGRAM;
                        prog_cnt_reg <= dsize_reg;
                        sync_cnt_reg <= 32'(PROG_CYC_PER_BYTE - 1);
                    end else if (is_cmd && !cmd_blocked) begin
                        cmd_reg  <= byte_data;
                        pidx_reg <= 3'h0;
                        state_reg <= (byte_data == CMD_NVM_READ || byte_data == CMD_FRAME_MEM_READ ||
                                      byte_data == CMD_LEVEL_READBACK || byte_data == CMD_PROG_RESULT)
                                     ? OCS_READ : OCS_PARAM;
                    end else if (is_cmd) begin
                        cmd_reg   <= 8'h00;
                        state_reg <= OCS_IDLE;
                    end else if (is_param && state_reg == OCS_PARAM) begin
                        pidx_reg <= pidx_reg + 3'h1;
                        if (cmd_reg == CMD_TEMP_PATH && pidx_reg == 3'h0 && byte_data[POS_CASCADE_EN]) begin
                            state_reg    <= OCS_SYNC;
                            sync_cnt_reg <= 32'(CASCADE_CYCLES - 1);
                        end
                    end
                end
                OCS_PROGRAM: begin
                    if (sync_cnt_reg != 32'h0) begin
                        sync_cnt_reg <= sync_cnt_reg - 32'h1;
                    end else if (prog_cnt_reg <= 16'h0001) begin
                        state_reg <= OCS_IDLE;
                    end else begin
                        prog_cnt_reg <= prog_cnt_reg - 16'h1;
                        sync_cnt_reg <= 32'(PROG_CYC_PER_BYTE - 1);
                    end
                end
                OCS_SYNC: begin
                    if (sync_cnt_reg == 32'h0)
                        state_reg <= OCS_IDLE;
                    else
                        sync_cnt_reg <= sync_cnt_reg - 32'h1;
                end
                default: state_reg <= OCS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Parameter registers
    logic wr;
    assign wr = is_param && state_reg == OCS_PARAM;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meas_reg      <= RST_MEASURE;
            dc_reg        <= RST_DC;
            cfg_reg       <= RST_PROG_CFG;
            saddr_reg     <= RST_PROG_ADDR;
            dsize_reg     <= RST_PROG_SIZE;
            temp_path_reg <= RST_TEMP_PATH;
            lv_reg        <= RST_LOW_VOLT;
            ftemp_reg     <= RST_FORCED_TEMP;
            hr_reg        <= RST_HIGH_RAIL;
            gs_reg        <= RST_GATE_STRENGTH;
            ps_reg        <= RST_PUMP_SEL;
            pe_reg        <= RST_PUMP_EN;
            ph_reg        <= RST_PUMP_HIGH;
            pl_reg        <= RST_PUMP_LOW;
            sr_reg        <= RST_SOURCE_RAIL;
            pwm_reg       <= RST_BOOST_PWM;
        end else if (wr) begin
            case (cmd_reg)
                CMD_MEASURE_SETUP:  if (pidx_reg == 3'h0) meas_reg <= byte_data;
                CMD_DC_SETTING:     if (pidx_reg == 3'h0) dc_reg <= byte_data;
                CMD_PROG_CONFIG: begin
                    case (pidx_reg)
                        3'h0:    cfg_reg <= byte_data;
                        3'h1:    saddr_reg[15:8] <= byte_data;
                        3'h2:    saddr_reg[7:0] <= byte_data;
                        3'h3:    dsize_reg[15:8] <= byte_data;
                        3'h4:    dsize_reg[7:0] <= byte_data;
                        default: cfg_reg <= cfg_reg;
                    endcase
                end
                CMD_TEMP_PATH:      if (pidx_reg == 3'h0) temp_path_reg <= byte_data;
                CMD_LOW_VOLT:       if (pidx_reg == 3'h0) lv_reg <= byte_data;
                CMD_FORCED_TEMP:    if (pidx_reg == 3'h0) ftemp_reg <= byte_data;
                CMD_HIGH_RAIL_COMP: if (pidx_reg == 3'h0) hr_reg <= byte_data;
                CMD_GATE_STRENGTH:  if (pidx_reg == 3'h0) gs_reg <= byte_data;
                CMD_PUMP_SEL:       if (pidx_reg == 3'h0) ps_reg <= byte_data;
                CMD_PUMP_EN:        if (pidx_reg == 3'h0) pe_reg <= byte_data;
                CMD_PUMP_HIGH:      if (pidx_reg == 3'h0) ph_reg <= byte_data;
                CMD_PUMP_LOW:       if (pidx_reg == 3'h0) pl_reg <= byte_data;
                CMD_SOURCE_RAIL:    if (pidx_reg == 3'h0) sr_reg <= byte_data;
                CMD_BOOST_PWM:      pwm_reg[63-8*pidx_reg -: 8] <= byte_data;
                default:            meas_reg <= meas_reg;
            endcase
        end
    end

    // ==========================================================
    // Mode flags; program mode is left only through reset.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            test_reg     <= 1'b0;
            pgm_mode_reg <= 1'b0;
        end else begin
            if (is_cmd && byte_data == CMD_ENTER_PROGRAM && !cmd_blocked && !busy_now)
                pgm_mode_reg <= 1'b1;
            if (wr && cmd_reg == CMD_TEST && pidx_reg == 3'h0) begin
                if (byte_data == TEST_ENTER_CODE)
                    test_reg <= 1'b1;
                else if (byte_data == TEST_EXIT_CODE)
                    test_reg <= 1'b0;
            end
        end
    end

    // Status flags are cleared when an activation starts; invalid is set when one is refused.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            verify_fail_reg <= 1'b0;
            invalid_reg     <= 1'b0;
        end else begin
            if (prog_start) begin
                verify_fail_reg <= 1'b0;
                invalid_reg     <= 1'b0;
            end else if (prog_invalid) begin
                invalid_reg <= 1'b1;
            end
            if (state_reg == OCS_PROGRAM && prog_verify_fail_in)
                verify_fail_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Readback: for 92H and 93H the first byte after the command is a dummy.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dummy_reg   <= 1'b1;
            rd_addr_reg <= '0;
            read_data   <= 8'h00;
        end else if (is_cmd) begin
            dummy_reg   <= 1'b1;
            rd_addr_reg <= '0;
        end else if (read_req && state_reg == OCS_READ) begin
            dummy_reg <= 1'b0;
            case (cmd_reg)
                CMD_NVM_READ, CMD_FRAME_MEM_READ: begin
                    if (dummy_reg) begin
                        read_data <= 8'h00;
                    end else begin
                        read_data   <= (cmd_reg == CMD_NVM_READ) ? nvm_rdata : frame_rdata;
                        rd_addr_reg <= rd_addr_reg + 1'b1;
                    end
                end
                CMD_LEVEL_READBACK: read_data <= {1'b0, (measured_level > LEVEL_CODE_MAX) ?
                                                  LEVEL_CODE_MAX : measured_level};
                CMD_PROG_RESULT:    read_data <= {6'h00, verify_fail_reg, invalid_reg};
                default:            read_data <= 8'h00;
            endcase
        end
    end
    assign nvm_addr   = rd_addr_reg;
    assign frame_addr = rd_addr_reg;

    // ==========================================================
    // Cascade clock: divided ref_clk when enabled, low otherwise.
    logic ccl_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            ccl_reg <= 1'b0;
        else if (temp_path_reg[POS_CASCADE_EN])
            ccl_reg <= !ccl_reg;
        else
            ccl_reg <= 1'b0;
    end
    assign cascade_clock_pin = ccl_reg;

    // Forced value clamped to its valid span.
    logic signed [7:0] ft;
    assign ft = ftemp_reg;
    assign temperature_value = temp_path_reg[POS_FIXED_TEMP] ?
        ((ft < TEMP_MIN) ? TEMP_MIN : (ft > TEMP_MAX) ? TEMP_MAX : ftemp_reg) : sensor_temp;

    assign auto_measure_en     = meas_reg[POS_MEASURE_EN];
    assign all_gate_on_sel     = meas_reg[POS_ALL_GATE] && meas_reg[POS_MEASURE_EN];
    assign source_level_sel    = meas_reg[POS_SOURCE_LEVEL];
    assign analog_probe_sel    = meas_reg[POS_ANALOG_PATH];
    assign sense_time_sel      = meas_reg[POS_SENSE_TIME +: 2];
    assign dc_level            = dc_reg[6:0];
    assign dc_level_source_sel = dc_reg[POS_DC_SOURCE];
    assign prog_voltage_sel    = cfg_reg[POS_PROG_VOLT];
    assign prog_start_addr     = saddr_reg;
    assign prog_data_size      = dsize_reg;
    assign program_mode        = pgm_mode_reg;
    assign prog_running        = state_reg == OCS_PROGRAM;
    assign low_voltage_sel     = lv_reg[1:0];
    assign test_mode           = test_reg;
    assign high_rail_comp      = hr_reg;
    assign gate_strength       = gs_reg;
    assign pump_sel            = ps_reg;
    assign pump_en             = pe_reg;
    assign pump_high           = ph_reg;
    assign pump_low            = pl_reg;
    assign source_rail         = sr_reg;
    assign boost_pwm           = pwm_reg;

    // ==========================================================
    // Checks
    a_busy_on_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        prog_start |=> !busy_n) else $error("busy not low after program start");
    a_refuse_busy: assert property (@(posedge ref_clk) disable iff (!nrst)
        !busy_n && is_cmd && byte_data == CMD_PROGRAM_ACT
        |=> $stable(invalid_reg) && prog_cnt_reg <= $past(prog_cnt_reg)) else $error("activate taken busy");
    a_pgm_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
        program_mode |=> program_mode) else $error("program mode left without reset");
    a_cascade_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        !temp_path_reg[POS_CASCADE_EN] |=> !cascade_clock_pin) else $error("cascade pin not low");
    a_cascade_toggle: assert property (@(posedge ref_clk) disable iff (!nrst)
        temp_path_reg[POS_CASCADE_EN] && $past(temp_path_reg[POS_CASCADE_EN])
        |=> cascade_clock_pin != $past(cascade_clock_pin)) else $error("cascade clock stuck");
    a_level_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == OCS_READ && cmd_reg == CMD_LEVEL_READBACK && read_req && !is_cmd
        |=> read_data <= 8'h50) else $error("readback code out of range");
    a_dummy_first: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == OCS_READ && (cmd_reg == CMD_NVM_READ || cmd_reg == CMD_FRAME_MEM_READ)
        && read_req && !is_cmd && dummy_reg |=> read_data == 8'h00) else $error("dummy byte not zero");
    a_addr_step: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == OCS_READ && cmd_reg == CMD_NVM_READ && read_req && !is_cmd && !dummy_reg
        |=> nvm_addr == $past(nvm_addr) + 1'b1) else $error("read address not stepped");
    a_blocked_cmd: assert property (@(posedge ref_clk) disable iff (!nrst)
        busy_n && is_cmd && cmd_blocked
        |=> cmd_reg == 8'h00 && !$rose(program_mode)) else $error("blocked cmd taken");
    a_verify_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        prog_running && prog_verify_fail_in |=> verify_fail_reg) else $error("verify failure lost");
    a_test_enter: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr && cmd_reg == CMD_TEST && pidx_reg == 3'h0 && byte_data == TEST_ENTER_CODE
        |=> test_mode) else $error("test mode not entered");
    a_fixed_temp: assert property (@(posedge ref_clk) disable iff (!nrst)
        !temp_path_reg[POS_FIXED_TEMP] |-> temperature_value == sensor_temp) else $error("sensor not used");
endmodule

// *** tb/ocs_mem_model.sv ***
/* Far-side model: memories, level sensor, temperature sensor.
   Assumes same-cycle read data on the shared address counter. */
module ocs_mem_model (
    input  wire logic [15:0] nvm_addr,
    input  wire logic [15:0] frame_addr,
    output logic      [7:0]  nvm_rdata,
    output logic      [7:0]  frame_rdata,
    output logic      [6:0]  measured_level,
    output logic      [7:0]  sensor_temp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Data differs per address, so an address slip shows up.
    assign nvm_rdata      = nvm_addr[7:0] ^ 8'h5A;
    assign frame_rdata    = frame_addr[7:0] + 8'h30;
    assign measured_level = 7'h50;
    assign sensor_temp    = 8'h11;
endmodule

// *** tb/ocs_cmd_test.sv ***
/* Self-checking bench for the command interpreter.
   Assumes the byte and read strobes of the serial front end. */
module ocs_cmd_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ocs_pkg::*;
    logic ref_clk = 0, nrst = 0, bv = 0, bc = 0, rq = 0, role = 1, vf = 0;
    logic [7:0] bd = 0, rdat, tv, nr, fr, st;
    logic busy_n, ccp, pm, pr, pvs, ame, ago, sls, aps, dcs, tm, p;
    logic [15:0] na, fa, psa, pds;
    logic [6:0] ml, dcl;
    logic [1:0] sts, lvs;
    logic [7:0] hr, gs, ps, pe, ph, pl, sr;
    logic [63:0] pw;
    int errors = 0, comparisons = 0, cyc = 0, n;
    ocs_mem_model mem (.nvm_addr(na), .frame_addr(fa), .nvm_rdata(nr), .frame_rdata(fr),
        .measured_level(ml), .sensor_temp(st));
    ocs_cmd #(.CASCADE_CYCLES(20)) dut (.ref_clk(ref_clk), .nrst(nrst), .byte_valid(bv),
        .byte_is_cmd(bc), .byte_data(bd), .read_req(rq), .read_data(rdat), .busy_n(busy_n),
        .role_select_pin(role), .cascade_clock_pin(ccp), .measured_level(ml), .sensor_temp(st),
        .nvm_addr(na), .nvm_rdata(nr), .frame_addr(fa), .frame_rdata(fr), .prog_verify_fail_in(vf),
        .program_mode(pm), .prog_running(pr), .prog_voltage_sel(pvs), .prog_start_addr(psa),
        .prog_data_size(pds), .auto_measure_en(ame), .all_gate_on_sel(ago), .source_level_sel(sls),
        .analog_probe_sel(aps), .sense_time_sel(sts), .dc_level(dcl), .dc_level_source_sel(dcs),
        .temperature_value(tv), .low_voltage_sel(lvs), .test_mode(tm), .high_rail_comp(hr),
        .gate_strength(gs), .pump_sel(ps), .pump_en(pe), .pump_high(ph), .pump_low(pl), .source_rail(sr),
        .boost_pwm(pw));
    always #2 ref_clk = ~ref_clk;
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic c, logic [7:0] d);
        @(negedge ref_clk) {bv, bc, bd} = {1'b1, c, d};
        @(negedge ref_clk) bv = 0;
        @(negedge ref_clk);
    endtask
    task automatic rd(string nm, logic [7:0] exp);
        @(negedge ref_clk) rq = 1;
        @(negedge ref_clk) rq = 0;
        chk(nm, rdat, exp);
    endtask
    task automatic cfg(logic [7:0] c);
        wr(1, CMD_PROG_CONFIG); wr(0, c); wr(0, 8'h12); wr(0, 8'h34); wr(0, 8'h00); wr(0, 8'h02);
    endtask
    // Busy is counted only while low, so a stuck line ends the wait at the bound.
    task automatic wait_ready();
        for (n = 0; busy_n !== 1'b1 && n < 500; n++) @(negedge ref_clk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cyc == 20000) begin errors++; print_verdict(); end
    initial begin
        repeat (16) @(negedge ref_clk);
        nrst = 1;
        repeat (3) @(negedge ref_clk);
        chk("reset", {lvs, pds, ame, ccp, busy_n}, {2'h3, 16'h15DF, 3'b001});
        chk("reset regs", {hr, gs, ps, pe, ph, pl, sr}, 56'h3FF8030308083F);
        chk("reset pwm", pw, 64'h0103030A04200620);
        wr(1, CMD_MEASURE_SETUP); wr(0, 8'h3F);
        chk("measure", {sts, ago, sls, aps, ame}, 6'h3F);
        wr(1, CMD_DC_SETTING); wr(0, 8'hD0);
        chk("dc", {dcs, dcl}, 8'hD0);
        wr(1, CMD_LEVEL_READBACK); rd("level", 8'h50);
        $display("test measure done");
        wr(1, CMD_FORCED_TEMP); wr(0, 8'h3C); wr(1, CMD_TEMP_PATH); wr(0, 8'h03);
        chk("sync busy", busy_n, 1'b0);
        p = ccp;
        @(negedge ref_clk) chk("ccpin", ccp ^ p, 1'b1);
        wait_ready(); chk("sync len", n inside {[15:21]}, 1'b1);
        chk("temp", tv, 8'h3C);
        wr(1, CMD_TEMP_PATH); wr(0, 8'h00); chk("sensor", {tv, ccp}, {8'h11, 1'b0});
        wr(1, CMD_LOW_VOLT); wr(0, 8'h00); chk("low_voltage_threshold", lvs, 2'h0);
        wr(1, CMD_TEST); wr(0, TEST_ENTER_CODE); chk("test on", tm, 1'b1);
        wr(1, CMD_TEST); wr(0, TEST_EXIT_CODE); chk("test off", tm, 1'b0);
        wr(1, CMD_BOOST_PWM); for (n = 0; n < 8; n++) wr(0, 8'(n + 1));
        chk("pwm", pw, 64'h0102030405060708);
        wr(1, CMD_GATE_STRENGTH); wr(0, 8'h5A); chk("gdr", gs, 8'h5A);
        $display("test config done");
        wr(1, CMD_NVM_READ); rd("dummy", 8'h00); rd("nvm0", 8'h5A); rd("nvm1", 8'h5B);
        wr(1, CMD_FRAME_MEM_READ); rd("dummy", 8'h00); rd("fm0", 8'h30); rd("fm1", 8'h31);
        $display("test readback done");
        cfg(8'h12); chk("cfg", {pvs, psa, pds}, {1'b1, 16'h1234, 16'h0002});
        wr(1, CMD_ENTER_PROGRAM); chk("blocked", pm, 1'b0);
        cfg(8'h10); wr(1, CMD_PROGRAM_ACT); wr(1, CMD_PROG_RESULT); rd("bad act", 8'h01);
        wr(1, CMD_ENTER_PROGRAM); chk("pmode", pm, 1'b1);
        wr(1, CMD_PROGRAM_ACT); chk("prog busy", {busy_n, pr}, 2'b01);
        wait_ready(); chk("prog len", n inside {[27:33]}, 1'b1);
        wr(1, CMD_PROG_RESULT); rd("status", 8'h00);
        chk("pmode held", pm, 1'b1);
        vf = 1; wr(1, CMD_PROGRAM_ACT); wr(1, CMD_PROGRAM_ACT); wait_ready(); vf = 0;
        chk("reprog len", n inside {[25:31]}, 1'b1);
        wr(1, CMD_PROG_RESULT); rd("verify", 8'h02);
        $display("test program done");
        nrst = 0; repeat (2) @(negedge ref_clk); nrst = 1; role = 0; repeat (3) @(negedge ref_clk);
        chk("reset exit", {pm, busy_n, pds}, {2'b01, 16'h15DF});
        cfg(8'h01); wr(1, CMD_ENTER_PROGRAM); chk("slave blk", pm, 1'b0);
        $display("test reset done");
        print_verdict();
    end
endmodule
